/* inc/uart_tx_pkg.sv */
package uart_tx_pkg;

   // ------------------------------------------------------------
   // Register byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_INTCTL   = 8'h00;
   localparam logic [7:0] ADDR_PFLAGS   = 8'h04;
   localparam logic [7:0] ADDR_PENABLE  = 8'h08;
   localparam logic [7:0] ADDR_PPRIO    = 8'h0C;
   localparam logic [7:0] ADDR_RXCTL    = 8'h10;
   localparam logic [7:0] ADDR_TXHOLD   = 8'h14;
   localparam logic [7:0] ADDR_TXCTL    = 8'h18;
   localparam logic [7:0] ADDR_BAUDCTL  = 8'h1C;
   localparam logic [7:0] ADDR_DIVHI    = 8'h20;
   localparam logic [7:0] ADDR_DIVLO    = 8'h24;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int BIT_GIE      = 7;  // interrupt_control
   localparam int BIT_PEIE     = 6;
   localparam int BIT_TXFLAG   = 4;  // peripheral flags / enables / priority
   localparam int BIT_PORTEN   = 7;  // receive_control_status
   localparam int BIT_NINESEL  = 6;  // transmit_control_status
   localparam int BIT_TRANSMIT_ENABLE     = 5;
   localparam int BIT_SYNCSEL  = 4;
   localparam int BIT_HIRATE   = 2;
   localparam int BIT_SHEMPTY  = 1;
   localparam int BIT_NINTHBIT = 0;
   localparam int BIT_POLSEL   = 4;  // baud_control
   localparam int BIT_WIDEDIV  = 3;

   // ------------------------------------------------------------
   // Widths, reset values, counts
   // ------------------------------------------------------------
   localparam int          REG_W       = 8;
   localparam int          FRAME_W     = 11;
   localparam logic [3:0]  BITS_8      = 4'hA;   // start + 8 data + stop
   localparam logic [3:0]  BITS_9      = 4'hB;   // start + 9 data + stop
   localparam logic [7:0]  RST_REG     = 8'h00;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   localparam logic [1:0]  FLAG_DELAY  = 2'h2;   // cycles until flag valid

   typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_t;

endpackage

/* hdl/uart_tx.sv */
`timescale 1ns/1ns
module uart_tx
   import uart_tx_pkg::*;
(
   input  wire logic        clk_in,            // 50 MHz system clock
   input  wire logic        reset_n_in,        // Async reset, active low
   input  wire logic        bit_tick_in,       // One-cycle bit-rate pulse
   input  wire logic        rx_pin_in,         // Receive pin level (unused here)
   input  wire logic [7:0]  s_axi_awaddr,      // Write address
   input  wire logic        s_axi_awvalid,     // Write address valid
   output logic             s_axi_awready,     // Write address ready
   input  wire logic [31:0] s_axi_wdata,       // Write data
   input  wire logic [3:0]  s_axi_wstrb,       // Write strobes
   input  wire logic        s_axi_wvalid,      // Write data valid
   output logic             s_axi_wready,      // Write data ready
   output logic [1:0]       s_axi_bresp,       // Write response
   output logic             s_axi_bvalid,      // Write response valid
   input  wire logic        s_axi_bready,      // Write response ready
   input  wire logic [7:0]  s_axi_araddr,      // Read address
   input  wire logic        s_axi_arvalid,     // Read address valid
   output logic             s_axi_arready,     // Read address ready
   output logic [31:0]      s_axi_rdata,       // Read data
   output logic [1:0]       s_axi_rresp,       // Read response
   output logic             s_axi_rvalid,      // Read data valid
   input  wire logic        s_axi_rready,      // Read data ready
   output logic             tx_pin_out,        // Transmit pin level
   output logic             tx_pin_oe_n_out,   // Transmit pin enable, low drives
   output logic             rx_pin_oe_n_out,   // Receive pin enable, high = input
   output logic             irq_out,           // Interrupt request
   output logic             wide_div_out,      // Divider width to baud generator
   output logic             high_rate_out,     // Rate select to baud generator
   output logic [15:0]      divisor_out        // Divisor to baud generator
);

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0]          intctl_r;
   logic [7:0]          penable_r;
   logic [7:0]          pprio_r;
   logic [7:0]          rxctl_r;
   logic [7:0]          txctl_r;
   logic [7:0]          baudctl_r;
   logic [7:0]          divhi_r;
   logic [7:0]          divlo_r;
   logic [8:0]          hold_r;
   logic                hold_full_r;
   logic [FRAME_W-1:0]  shift_r;
   logic [3:0]          bits_left_r;
   tx_state_t           state_r;
   logic                started_r;
   logic [1:0]          flag_dly_r;
   logic                flag_r;
   logic                aw_got_r;
   logic                w_got_r;
   logic [7:0]          aw_addr_r;
   logic [31:0]         w_data_r;
   logic [3:0]          w_strb_r;

   logic tx_active;
   logic wr_fire;
   logic hold_wr;
   logic load_now;

   // transmitter runs only when enabled, asynchronous and port on
   assign tx_active = txctl_r[BIT_TRANSMIT_ENABLE] & ~txctl_r[BIT_SYNCSEL] & rxctl_r[BIT_PORTEN];
   assign wr_fire   = aw_got_r & w_got_r & ~s_axi_bvalid;
   assign hold_wr   = wr_fire & (aw_addr_r == ADDR_TXHOLD) & w_strb_r[0];
   // move into shifter whenever shifter free and character queued
   assign load_now  = tx_active & hold_full_r
                      & ((state_r == TX_IDLE)
                         | (bit_tick_in & started_r & (bits_left_r == 4'h1)));

   function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
      merge_byte = strb[0] ? data[7:0] : old_v;
   endfunction

   // ------------------------------------------------------------
   // AXI4-Lite write channel
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         aw_got_r  <= 1'b0;
         w_got_r   <= 1'b0;
         aw_addr_r <= RST_REG;
         w_data_r  <= '0;
         w_strb_r  <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r  <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_got_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r  <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_got_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         s_axi_awready <= ~aw_got_r & ~(s_axi_awvalid & s_axi_awready);
         s_axi_wready  <= ~w_got_r & ~(s_axi_wvalid & s_axi_wready);
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_r > ADDR_DIVLO || aw_addr_r[1:0] != 2'h0)
                            ? RESP_SLVERR : RESP_OKAY;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Software-written control registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         intctl_r  <= RST_REG;
         penable_r <= RST_REG;
         pprio_r   <= RST_REG;
         rxctl_r   <= RST_REG;
         txctl_r   <= RST_REG;
         baudctl_r <= RST_REG;
         divhi_r   <= RST_REG;
         divlo_r   <= RST_REG;
      end else if (wr_fire) begin
         unique case (aw_addr_r)
            ADDR_INTCTL:  intctl_r  <= merge_byte(intctl_r, w_data_r, w_strb_r);
            ADDR_PENABLE: penable_r <= merge_byte(penable_r, w_data_r, w_strb_r);
            ADDR_PPRIO:   pprio_r   <= merge_byte(pprio_r, w_data_r, w_strb_r);
            ADDR_RXCTL:   rxctl_r   <= merge_byte(rxctl_r, w_data_r, w_strb_r);
            // Shifter-empty bit is status; software copy ignored
            ADDR_TXCTL:   txctl_r   <= merge_byte(txctl_r, w_data_r, w_strb_r);
            ADDR_BAUDCTL: baudctl_r <= merge_byte(baudctl_r, w_data_r, w_strb_r);
            ADDR_DIVHI:   divhi_r   <= merge_byte(divhi_r, w_data_r, w_strb_r);
            ADDR_DIVLO:   divlo_r   <= merge_byte(divlo_r, w_data_r, w_strb_r);
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Holding register
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         hold_r      <= '0;
         hold_full_r <= 1'b0;
      end else if (!tx_active) begin
         hold_full_r <= 1'b0;
      end else if (hold_wr) begin
         // Ninth bit sampled at the low-byte write, so all nine move together
         hold_r      <= {txctl_r[BIT_NINTHBIT], w_data_r[7:0]};
         hold_full_r <= 1'b1;
      end else if (load_now) begin
         hold_full_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Transmit shifter
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_r     <= TX_IDLE;
         shift_r     <= '1;
         bits_left_r <= '0;
         started_r   <= 1'b0;
      end else if (!tx_active) begin
         state_r     <= TX_IDLE;
         shift_r     <= '1;
         bits_left_r <= '0;
         started_r   <= 1'b0;
      end else if (load_now) begin
         // Frame: stop(s) high, data LSB first, start low
         shift_r     <= txctl_r[BIT_NINESEL]
                        ? {1'b1, hold_r, 1'b0}
                        : {2'b11, hold_r[7:0], 1'b0};
         bits_left_r <= txctl_r[BIT_NINESEL] ? BITS_9 : BITS_8;
         state_r     <= TX_SHIFT;
         // Reload on the stop tick is already on the bit grid
         started_r   <= (state_r == TX_SHIFT);
      end else begin
         unique case (state_r)
            TX_IDLE: ;
            TX_SHIFT: begin
               // Line waits at mark for a tick, so the start bit is a full period
               if (bit_tick_in && !started_r) begin
                  started_r <= 1'b1;
               end else if (bit_tick_in) begin
                  shift_r     <= {1'b1, shift_r[FRAME_W-1:1]};
                  bits_left_r <= bits_left_r - 4'h1;
                  if (bits_left_r == 4'h1) begin
                     state_r <= TX_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Buffer-empty flag with write latency
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         flag_dly_r <= '0;
         flag_r     <= 1'b0;
      end else begin
         flag_dly_r <= hold_wr ? FLAG_DELAY : (flag_dly_r != 2'h0 ? flag_dly_r - 2'h1 : 2'h0);
         if (!tx_active) begin
            flag_r <= 1'b0;
         end else if (hold_wr || flag_dly_r > 2'h1) begin
            flag_r <= flag_r;
         end else begin
            flag_r <= ~hold_full_r;
         end
      end
   end

   // ------------------------------------------------------------
   // Pins and outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tx_pin_out      <= 1'b1;
         tx_pin_oe_n_out <= 1'b1;
         rx_pin_oe_n_out <= 1'b1;
         irq_out         <= 1'b0;
         wide_div_out    <= 1'b0;
         high_rate_out   <= 1'b0;
         divisor_out     <= '0;
      end else begin
         tx_pin_out      <= (shift_r[0] | ~started_r) ^ baudctl_r[BIT_POLSEL];
         tx_pin_oe_n_out <= ~rxctl_r[BIT_PORTEN];
         rx_pin_oe_n_out <= 1'b1;
         irq_out         <= flag_r & penable_r[BIT_TXFLAG] & intctl_r[BIT_GIE]
                            & intctl_r[BIT_PEIE];
         wide_div_out    <= baudctl_r[BIT_WIDEDIV];
         high_rate_out   <= txctl_r[BIT_HIRATE];
         divisor_out     <= {divhi_r, divlo_r};
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            s_axi_rdata  <= '0;
            unique case (s_axi_araddr)
               ADDR_INTCTL:  s_axi_rdata[7:0] <= intctl_r;
               ADDR_PFLAGS:  s_axi_rdata[BIT_TXFLAG] <= flag_r;
               ADDR_PENABLE: s_axi_rdata[7:0] <= penable_r;
               ADDR_PPRIO:   s_axi_rdata[7:0] <= pprio_r;
               ADDR_RXCTL:   s_axi_rdata[7:0] <= rxctl_r;
               ADDR_TXHOLD:  s_axi_rdata[7:0] <= RST_REG;
               ADDR_TXCTL:   s_axi_rdata[7:0] <= {txctl_r[7:2], state_r == TX_IDLE,
                                                  txctl_r[BIT_NINTHBIT]};
               ADDR_BAUDCTL: s_axi_rdata[7:0] <= baudctl_r;
               ADDR_DIVHI:   s_axi_rdata[7:0] <= divhi_r;
               ADDR_DIVLO:   s_axi_rdata[7:0] <= divlo_r;
               default:      s_axi_rresp <= RESP_SLVERR;
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule // uart_tx

/* testbench/uart_tx_properties.sv */
`timescale 1ns/1ns
module uart_tx_checker
   import uart_tx_pkg::*;
(
   input wire logic        clk_in,          // Clock
   input wire logic        reset_n_in,      // Reset, active low
   input wire logic        s_axi_awvalid,   // Bus signals
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        rx_pin_oe_n_out  // Receive pin enable
);
   // ----------------------------------------
   // Bus and pin properties
   // ----------------------------------------
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   property p_aw_drop;
      s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
   endproperty
   property p_b_late;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |=> !s_axi_bvalid ##1 s_axi_bvalid;
   endproperty
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_r_late;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_unmap;
      s_axi_arvalid && s_axi_arready && s_axi_araddr > ADDR_DIVLO
         |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   property p_mapped;
      s_axi_arvalid && s_axi_arready && s_axi_araddr <= ADDR_DIVLO
         && s_axi_araddr[1:0] == 2'h0 |=> s_axi_rresp == RESP_OKAY;
   endproperty
   property p_rx_in;
      rx_pin_oe_n_out;
   endproperty
   a_aw_drop: assert property (p_aw_drop) else $error("awready stayed high");
   a_b_late: assert property (p_b_late) else $error("write answer late");
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   a_r_late: assert property (p_r_late) else $error("read answer late");
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
   a_unmap: assert property (p_unmap) else $error("unmapped read answered");
   a_mapped: assert property (p_mapped) else $error("mapped read refused");
   a_rx_in: assert property (p_rx_in) else $error("receive pin driven");
   c_wr: cover property (s_axi_bvalid && s_axi_bready);
   c_err: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == RESP_SLVERR);
   c_rd: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == RESP_OKAY);
endmodule // uart_tx_checker

bind uart_tx uart_tx_checker u_chk (.*);

/* testbench/uart_line_rx.sv */
`timescale 1ns/1ns
module uart_line_rx (
   input  wire logic       clk_in,   // Bench clock
   input  wire logic       line_in,  // Serial line
   input  wire logic       tick_in,  // Bit tick
   input  wire logic       nine_in,  // Nine data bits
   input  wire logic       inv_in,   // Inverted line
   input  wire logic       en_in,    // Listening
   output logic            got_out,  // Character ready
   output logic [8:0]      data_out, // Character
   output logic            err_out   // Bad start or stop
);
   // ----------------------------------------
   // Sampling at each tick, line already settled
   // ----------------------------------------
   logic [10:0] sh_r = 11'h0;
   logic [10:0] sh_nxt;
   logic [3:0]  cnt_r = 4'h0;
   logic        busy_r = 1'b0;
   logic        lvl;
   assign lvl    = line_in ^ inv_in;
   assign sh_nxt = {lvl, sh_r[10:1]};
   always @(posedge clk_in) begin
      got_out <= 1'b0;
      if (en_in && (busy_r || !lvl)) begin
         busy_r <= 1'b1;
         if (tick_in) begin
            sh_r  <= sh_nxt;
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == (nine_in ? 4'hA : 4'h9)) begin
               busy_r   <= 1'b0;
               cnt_r    <= 4'h0;
               got_out  <= 1'b1;
               data_out <= nine_in ? sh_nxt[9:1] : {1'b0, sh_nxt[9:2]};
               err_out  <= !sh_nxt[10] || (nine_in ? sh_nxt[0] : sh_nxt[1]);
            end
         end
      end
   end
endmodule // uart_line_rx

/* testbench/uart_tx_tb_top.sv */
`timescale 1ns/1ns
module uart_tx_tb_top
   import uart_tx_pkg::*;
;
   logic        clk_in = 1'b0, reset_n_in = 1'b0, bit_tick_in = 1'b0, rx_pin_in = 1'b1;
   logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, d;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic        tx_pin_out, tx_pin_oe_n_out, rx_pin_oe_n_out, irq_out;
   logic        wide_div_out, high_rate_out, got, rx_err, n9;
   logic [15:0] divisor_out;
   logic        nine = 1'b0, inv = 1'b0, listen = 1'b0;
   logic [8:0]  rx_data;
   logic [8:0]  exp_q[$];
   logic [2:0]  tdiv = 3'h0;
   int          bad_count = 0, cmp_count = 0, cyc = 0, m, k, seed = 86;

   uart_tx dut (.*);
   uart_line_rx rx_m (.clk_in(clk_in), .line_in(tx_pin_out), .tick_in(bit_tick_in),
      .nine_in(nine), .inv_in(inv), .en_in(listen), .got_out(got), .data_out(rx_data),
      .err_out(rx_err));

   // ----------------------------------------
   // Clock, bit tick, timeout
   // ----------------------------------------
   always #10 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      tdiv        <= tdiv + 3'h1;
      bit_tick_in <= (tdiv == 3'h7);
      cyc++;
      if (cyc == 30000) begin
         bad_count++;
         end_sim();
      end
   end

   task automatic end_sim;
      $display("checks %0d errors %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h0, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge clk_in);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      @(posedge clk_in);
   endtask

   task automatic rd(input logic [7:0] a);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge clk_in);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata[7:0];
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clk_in);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      rd(a);
      chk($sformatf("reg %h", a), {1'b0, e}, {1'b0, d});
   endtask

   task automatic poll(input logic [7:0] a, input int b);
      do rd(a); while (d[b] !== 1'b1);
   endtask

   // ----------------------------------------
   // Received characters against notes
   // ----------------------------------------
   always @(posedge clk_in) begin
      if (got === 1'b1) begin
         chk("frame", 9'h0, 9'(rx_err));
         if (exp_q.size() == 0) chk("spare", 9'h0, rx_data);
         else chk("char", exp_q.pop_front(), rx_data);
      end
   end

   initial begin
      repeat (4) @(posedge clk_in);
      reset_n_in <= 1'b1;
      @(posedge clk_in);
      rchk(ADDR_PFLAGS, 8'h00);
      rchk(ADDR_TXCTL, 8'h02);
      rd(8'h28);
      chk("resp", 9'(RESP_SLVERR), 9'(r));
      wr(ADDR_RXCTL, 8'h80);
      chk("oe", 9'h0, 9'(tx_pin_oe_n_out));
      wr(ADDR_TXCTL, 8'h20);
      rchk(ADDR_PFLAGS, 8'h10);
      wr(ADDR_PFLAGS, 8'h00);
      rchk(ADDR_PFLAGS, 8'h10);
      wr(ADDR_INTCTL, 8'hC0);
      wr(ADDR_PENABLE, 8'h10);
      @(posedge clk_in);
      chk("irq", 9'h1, 9'(irq_out));
      wr(ADDR_INTCTL, 8'h40);
      @(posedge clk_in);
      chk("irq", 9'h0, 9'(irq_out));
      for (m = 0; m < 4; m++) begin
         listen <= 1'b0;
         nine   <= m[0];
         inv    <= m[1];
         wr(ADDR_BAUDCTL, {3'h0, m[1], 4'h0});
         chk("idle", 9'(!m[1]), 9'(tx_pin_out));
         listen <= 1'b1;
         for (k = 0; k < 3; k++) begin
            d  = $random(seed);
            n9 = $random(seed) & m[0];
            wr(ADDR_TXCTL, {1'b0, m[0], 1'b1, 4'h0, n9});
            exp_q.push_back({n9, d});
            wr(ADDR_TXHOLD, d);
            rchk(ADDR_PFLAGS, (k == 0) ? 8'h10 : 8'h00);
            poll(ADDR_PFLAGS, BIT_TXFLAG);
         end
         poll(ADDR_TXCTL, BIT_SHEMPTY);
      end
      wr(ADDR_TXCTL, 8'h30);
      rchk(ADDR_PFLAGS, 8'h00);
      repeat (20) @(posedge clk_in);
      chk("left", 9'h0, 9'(exp_q.size()));
      end_sim();
   end
endmodule // uart_tx_tb_top
